// ==== hdl/gpb_gpio.v ====
// Three-bank GPIO unit with masked access, pin interrupts and AXI4-Lite slave
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "gpb_map.vh"

// Summary of operation
// - Three 16-pin banks, each pin configurable
// - Reset: plain pins input, shared pins routed
// - Bank interrupt is OR of sixteen pins
// - Bank 1 low pins get dedicated interrupts
// - Enable, polarity, type select trigger kind
// - Detection sets sticky status and interrupt lines
// - Writing one at status clears flag
// - Two sync flops plus status stage
// - Reads answer one cycle after handshake, writes two
// - Two 256-word masked arrays, index is mask
// - Masked write changes only selected output bits
// - High array acts on bits 15..8
// - Soft reset keeps pins when option set
// - Peripheral routing by set and clear
// - Drive enable zero makes unrouted pin input
// - Pull active only when enabled, direction
// - Data read pins, data write outputs
// - Output pins driven push-pull
module gpb_gpio #(
	parameter [47:0] ALT_PRESENT = 48'h0000_0000_0000
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        soft_rst_req,
	input  wire [47:0] pin_in,
	output wire [47:0] pin_out,
	output wire [47:0] pin_oe,
	output wire [47:0] pull_up_en,
	output wire [47:0] pull_down_en,
	output wire [47:0] periph_route,
	input  wire [47:0] periph_out,
	input  wire [47:0] periph_oe,
	output wire [47:0] per_pin_irq_lines,
	output wire [2:0]  bank_combined_irq,
	output wire [7:0]  dedicated_irq
);

	// ======================================================================
	// Pin state and configuration, 16 bits per bank, soft_keep one bit per bank
	reg  [47:0] dout;
	reg  [47:0] drive_en;
	reg  [47:0] alt_sel;
	reg  [47:0] irq_en;
	reg  [47:0] irq_edge;
	reg  [47:0] irq_pol;
	reg  [47:0] irq_status_flags;
	reg  [47:0] pull_en;
	reg  [47:0] pull_dir;
	reg  [2:0]  soft_keep;
	reg  [47:0] pin_s1;
	reg  [47:0] pin_s2;
	reg  [47:0] pin_s3;

	// ======================================================================
	// AXI holding registers
	reg         aw_held;
	reg  [13:0] aw_addr;
	reg         w_held;
	reg  [15:0] w_data;
	reg  [1:0]  w_strb;

	wire        wr_fire;
	wire [1:0]  wb;
	wire [11:0] woff;
	wire [15:0] wm16;
	wire [15:0] wd_m;
	wire [7:0]  widx;
	wire [47:0] irq_status_clear;
	wire [47:0] lvl_hit;
	wire [47:0] edge_hit;
	wire [47:0] det;
	wire [47:0] keep48;
	wire        rd_fire;
	wire [1:0]  rb;
	wire [11:0] roff;
	wire [15:0] pins_r;
	reg  [15:0] rmux;
	reg  [15:0] nb;
	reg  [15:0] next_bank;
	reg  [47:0] next_dout;

	// ======================================================================
	// Address check shared by both channels
	function addr_ok;
		input [13:0] a;
		begin
			case ({a[11:2], 2'h0})
				`GPB_OFF_DATA, `GPB_OFF_DOUT, `GPB_OFF_OE_SET, `GPB_OFF_OE_CLR,
				`GPB_OFF_ALT_SET, `GPB_OFF_ALT_CLR, `GPB_OFF_IEN_SET,
				`GPB_OFF_IEN_CLR, `GPB_OFF_ITYP_SET, `GPB_OFF_ITYP_CLR,
				`GPB_OFF_IPOL_SET, `GPB_OFF_IPOL_CLR, `GPB_OFF_STATUS,
				`GPB_OFF_SOFT, `GPB_OFF_PULL_EN, `GPB_OFF_PULL_DIR: begin
					addr_ok = 1'b1;
				end
				default: begin
					addr_ok = (a[11:10] == `GPB_MASK_LO_SEL) || (a[11:10] == `GPB_MASK_HI_SEL);
				end
			endcase
			addr_ok = addr_ok && (a[13:12] != `GPB_BANK_NONE);
		end
	endfunction

	// ======================================================================
	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wb            = aw_addr[13:12];
	assign woff          = {aw_addr[11:2], 2'h0};
	assign widx          = aw_addr[9:2];
	assign wm16          = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	assign wd_m          = w_data & wm16;
	assign irq_status_clear = (wr_fire && woff == `GPB_OFF_STATUS && wb != `GPB_BANK_NONE) ?
		({32'h0000_0000, wd_m} << (wb * 16)) : 48'h0000_0000_0000;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			aw_addr      <= 14'h0000;
			w_held       <= 1'b0;
			w_data       <= 16'h0000;
			w_strb       <= 2'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `GPB_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[13:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata[15:0];
				w_strb <= s_axi_wstrb[1:0];
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_addr) ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Interrupt detection on synchronised pins
	assign lvl_hit  = ~(pin_s2 ^ irq_pol);
	assign edge_hit = lvl_hit & (pin_s3 ^ irq_pol);
	assign det      = irq_en & ((irq_edge & edge_hit) | (~irq_edge & lvl_hit));

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1 <= 48'h0000_0000_0000;
			pin_s2 <= 48'h0000_0000_0000;
			pin_s3 <= 48'h0000_0000_0000;
		end else begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// ======================================================================
	// Set/clear register update for the written bank
	always @* begin
		nb = drive_en[wb*16 +: 16];
		case (woff)
			`GPB_OFF_OE_SET, `GPB_OFF_OE_CLR:     nb = drive_en[wb*16 +: 16];
			`GPB_OFF_ALT_SET, `GPB_OFF_ALT_CLR:   nb = alt_sel[wb*16 +: 16];
			`GPB_OFF_IEN_SET, `GPB_OFF_IEN_CLR:   nb = irq_en[wb*16 +: 16];
			`GPB_OFF_ITYP_SET, `GPB_OFF_ITYP_CLR: nb = irq_edge[wb*16 +: 16];
			`GPB_OFF_IPOL_SET, `GPB_OFF_IPOL_CLR: nb = irq_pol[wb*16 +: 16];
			`GPB_OFF_PULL_EN:                     nb = pull_en[wb*16 +: 16];
			`GPB_OFF_PULL_DIR:                    nb = pull_dir[wb*16 +: 16];
			default:                              nb = dout[wb*16 +: 16];
		endcase
		// Set addresses have bit 2 clear, clear addresses have it set
		if (woff == `GPB_OFF_PULL_EN || woff == `GPB_OFF_PULL_DIR || woff == `GPB_OFF_DOUT ||
			woff == `GPB_OFF_DATA)
			next_bank = (nb & ~wm16) | wd_m;
		else if (woff[2])
			next_bank = nb & ~wd_m;
		else
			next_bank = nb | wd_m;
		next_dout = dout;
		if (aw_addr[11:10] == `GPB_MASK_LO_SEL)
			next_dout[wb*16 +: 8] = (dout[wb*16 +: 8] & ~widx) | (w_data[7:0] & widx);
		else if (aw_addr[11:10] == `GPB_MASK_HI_SEL)
			next_dout[wb*16+8 +: 8] = (dout[wb*16+8 +: 8] & ~widx) | (w_data[15:8] & widx);
		else
			next_dout[wb*16 +: 16] = next_bank;
	end

	assign keep48 = {{16{soft_keep[2]}}, {16{soft_keep[1]}}, {16{soft_keep[0]}}};

	// ======================================================================
	// Configuration and status registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			dout             <= {3{`GPB_PIN_RST}};
			drive_en         <= {3{`GPB_PIN_RST}};
			alt_sel          <= ALT_PRESENT;
			irq_en           <= {3{`GPB_PIN_RST}};
			irq_edge         <= {3{`GPB_PIN_RST}};
			irq_pol          <= {3{`GPB_PIN_RST}};
			irq_status_flags <= {3{`GPB_PIN_RST}};
			pull_en          <= {3{`GPB_PIN_RST}};
			pull_dir         <= {3{`GPB_PIN_RST}};
			soft_keep        <= 3'h0;
		end else if (soft_rst_req) begin
			// A bus write landing together with a soft reset is dropped
			dout             <= dout & keep48;
			drive_en         <= drive_en & keep48;
			alt_sel          <= (alt_sel & keep48) | (ALT_PRESENT & ~keep48);
			pull_en          <= pull_en & keep48;
			pull_dir         <= pull_dir & keep48;
			irq_en           <= {3{`GPB_PIN_RST}};
			irq_edge         <= {3{`GPB_PIN_RST}};
			irq_pol          <= {3{`GPB_PIN_RST}};
			irq_status_flags <= det;
		end else begin
			// A new detection wins over a clear in the same cycle
			irq_status_flags <= (irq_status_flags & ~irq_status_clear) | det;
			if (wr_fire && addr_ok(aw_addr)) begin
				if (aw_addr[11:10] != 2'h0) begin
					dout <= next_dout;
				end else begin
					case (woff)
						`GPB_OFF_DATA, `GPB_OFF_DOUT: begin
							dout <= next_dout;
						end
						`GPB_OFF_OE_SET, `GPB_OFF_OE_CLR: begin
							drive_en[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_ALT_SET, `GPB_OFF_ALT_CLR: begin
							alt_sel[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_IEN_SET, `GPB_OFF_IEN_CLR: begin
							irq_en[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_ITYP_SET, `GPB_OFF_ITYP_CLR: begin
							irq_edge[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_IPOL_SET, `GPB_OFF_IPOL_CLR: begin
							irq_pol[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_PULL_EN: begin
							pull_en[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_PULL_DIR: begin
							pull_dir[wb*16 +: 16] <= next_bank;
						end
						`GPB_OFF_SOFT: begin
							if (w_strb[0])
								soft_keep[wb] <= w_data[`GPB_SOFT_KEEP_BIT];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ======================================================================
	// Read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rb            = s_axi_araddr[13:12];
	assign roff          = {s_axi_araddr[11:2], 2'h0};
	assign pins_r        = pin_s2[rb*16 +: 16];

	always @* begin
		rmux = 16'h0000;
		if (s_axi_araddr[11:10] == `GPB_MASK_LO_SEL)
			rmux = {8'h00, pins_r[7:0] & s_axi_araddr[9:2]};
		else if (s_axi_araddr[11:10] == `GPB_MASK_HI_SEL)
			rmux = {pins_r[15:8] & s_axi_araddr[9:2], 8'h00};
		else begin
			case (roff)
				`GPB_OFF_DATA: begin
					rmux = pins_r;
				end
				`GPB_OFF_DOUT: begin
					rmux = dout[rb*16 +: 16];
				end
				`GPB_OFF_OE_SET, `GPB_OFF_OE_CLR: begin
					rmux = drive_en[rb*16 +: 16];
				end
				`GPB_OFF_ALT_SET, `GPB_OFF_ALT_CLR: begin
					rmux = alt_sel[rb*16 +: 16];
				end
				`GPB_OFF_IEN_SET, `GPB_OFF_IEN_CLR: begin
					rmux = irq_en[rb*16 +: 16];
				end
				`GPB_OFF_ITYP_SET, `GPB_OFF_ITYP_CLR: begin
					rmux = irq_edge[rb*16 +: 16];
				end
				`GPB_OFF_IPOL_SET, `GPB_OFF_IPOL_CLR: begin
					rmux = irq_pol[rb*16 +: 16];
				end
				`GPB_OFF_STATUS: begin
					rmux = irq_status_flags[rb*16 +: 16];
				end
				`GPB_OFF_SOFT: begin
					rmux = {15'h0000, soft_keep[rb]};
				end
				`GPB_OFF_PULL_EN: begin
					rmux = pull_en[rb*16 +: 16];
				end
				`GPB_OFF_PULL_DIR: begin
					rmux = pull_dir[rb*16 +: 16];
				end
				default: begin
					rmux = 16'h0000;
				end
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `GPB_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= addr_ok(s_axi_araddr[13:0]) ? {16'h0000, rmux} : 32'h0000_0000;
			s_axi_rresp  <= addr_ok(s_axi_araddr[13:0]) ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// Pin drivers and interrupt outputs
	assign pin_out           = (alt_sel & periph_out) | (~alt_sel & dout);
	assign pin_oe            = (alt_sel & periph_oe) | (~alt_sel & drive_en);
	assign periph_route      = alt_sel;
	assign pull_up_en        = pull_en & pull_dir;
	assign pull_down_en      = pull_en & ~pull_dir;
	assign per_pin_irq_lines = irq_status_flags;
	assign bank_combined_irq = {|irq_status_flags[47:32], |irq_status_flags[31:16],
		|irq_status_flags[15:0]};
	assign dedicated_irq     = irq_status_flags[23:16];

endmodule
`default_nettype wire

// ==== hdl/gpb_map.vh ====
// Register map, reset values and bus answers of the three-bank GPIO unit
`ifndef GPB_MAP_VH
`define GPB_MAP_VH

// ==========================================================================
// Register offsets inside one bank window
`define GPB_OFF_DATA      12'h000
`define GPB_OFF_DOUT      12'h004
`define GPB_OFF_OE_SET    12'h010
`define GPB_OFF_OE_CLR    12'h014
`define GPB_OFF_ALT_SET   12'h018
`define GPB_OFF_ALT_CLR   12'h01C
`define GPB_OFF_IEN_SET   12'h020
`define GPB_OFF_IEN_CLR   12'h024
`define GPB_OFF_ITYP_SET  12'h028
`define GPB_OFF_ITYP_CLR  12'h02C
`define GPB_OFF_IPOL_SET  12'h030
`define GPB_OFF_IPOL_CLR  12'h034
`define GPB_OFF_STATUS    12'h038
`define GPB_OFF_SOFT      12'h03C
`define GPB_OFF_PULL_EN   12'h040
`define GPB_OFF_PULL_DIR  12'h044

// ==========================================================================
// Masked arrays: selected by offset bits [11:10]
`define GPB_MASK_LO_SEL   2'h1
`define GPB_MASK_HI_SEL   2'h2

// ==========================================================================
// Bank select: address bits [13:12], this code is unmapped
`define GPB_BANK_NONE     2'h3

// ==========================================================================
// Reset values and field positions
`define GPB_PIN_RST       16'h0000
`define GPB_SOFT_KEEP_BIT 0

// ==========================================================================
// AXI responses
`define GPB_RESP_OKAY     2'h0
`define GPB_RESP_SLVERR   2'h2

`endif

// ==== verification/gpb_gpio_chk.sv ====
// Concurrent checks on the ports of the three-bank GPIO unit
`timescale 1ns/10ps
`default_nettype none
module gpb_gpio_chk #(
	parameter [47:0] ALT_PRESENT = 48'h0000_0000_0000
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        soft_rst_req,
	input wire logic [47:0] pin_out,
	input wire logic [47:0] pin_oe,
	input wire logic [47:0] pull_up_en,
	input wire logic [47:0] pull_down_en,
	input wire logic [47:0] periph_route,
	input wire logic [47:0] periph_out,
	input wire logic [47:0] periph_oe,
	input wire logic [47:0] per_pin_irq_lines,
	input wire logic [2:0]  bank_combined_irq,
	input wire logic [7:0]  dedicated_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bank_or: assert property (bank_combined_irq == {|per_pin_irq_lines[47:32],
		|per_pin_irq_lines[31:16], |per_pin_irq_lines[15:0]}) else $error("bank irq not OR of pins");
	chk_dedicated_map: assert property (dedicated_irq == per_pin_irq_lines[23:16])
		else $error("dedicated irq lines misplaced");
	chk_route_drive: assert property ((((pin_oe ^ periph_oe) | (pin_out ^ periph_out))
		& periph_route) == 48'h0) else $error("routed pin not driven by peripheral");
	chk_pull_gate: assert property ((pull_up_en & pull_down_en) == 48'h0)
		else $error("pull up and down both on");
	chk_reset_state: assert property (!$past(aresetn) |-> periph_route == ALT_PRESENT
		&& per_pin_irq_lines == 48'h0 && (pin_oe & ~periph_route) == 48'h0)
		else $error("state after reset wrong");
	chk_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	chk_status_sticky: assert property (($past(per_pin_irq_lines) & ~per_pin_irq_lines) != 48'h0
		|-> $rose(s_axi_bvalid) || $past(soft_rst_req)) else $error("status lost without clear");
endmodule
bind gpb_gpio gpb_gpio_chk #(.ALT_PRESENT(ALT_PRESENT)) chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.soft_rst_req(soft_rst_req), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .periph_route(periph_route), .periph_out(periph_out),
	.periph_oe(periph_oe), .per_pin_irq_lines(per_pin_irq_lines),
	.bank_combined_irq(bank_combined_irq), .dedicated_irq(dedicated_irq));
`default_nettype wire

// ==== verification/gpb_pad_model.sv ====
// Pad model: pin level from core drive, far-side drive and pull resistors
`timescale 1ns/10ps
`default_nettype none
module gpb_pad_model (
	input  wire logic        aclk,
	input  wire logic [47:0] pin_out,
	input  wire logic [47:0] pin_oe,
	input  wire logic [47:0] pull_up_en,
	input  wire logic [47:0] pull_down_en,
	input  wire logic [47:0] ext_drv,
	input  wire logic [47:0] ext_val,
	output logic      [47:0] pin_in
);
	logic [47:0] float_pat = 48'h0;
	// Undriven, unpulled pads wander every cycle
	always @(posedge aclk) float_pat <= ~float_pat;
	always_comb begin
		pin_in = pin_oe & pin_out;
		pin_in |= ~pin_oe & ext_drv & ext_val;
		pin_in |= ~pin_oe & ~ext_drv & (pull_up_en | (~pull_down_en & float_pat));
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the three-bank GPIO unit
`timescale 1ns/10ps
`default_nettype none
`include "gpb_map.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	localparam [47:0] ALT = 48'h0000_0001_0000;
	logic        aclk = 0, aresetn = 0, soft_rst_req = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, q;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid;
	logic [3:0]  s_axi_wstrb = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, qr;
	logic [47:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, periph_route;
	logic [47:0] per_pin_irq_lines, periph_out = 48'hAAAA_AAAA_AAAA, periph_oe = '1;
	logic [47:0] ext_drv = 48'h0000_FFFF_FFFF, ext_val = 48'h0000_0000_5A3C;
	logic [2:0]  bank_combined_irq;
	logic [7:0]  dedicated_irq;
	int          err_count = 0, n_tests = 0, m;
	gpb_gpio #(.ALT_PRESENT(ALT)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.soft_rst_req(soft_rst_req), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .periph_route(periph_route),
		.periph_out(periph_out), .periph_oe(periph_oe),
		.per_pin_irq_lines(per_pin_irq_lines), .bank_combined_irq(bank_combined_irq),
		.dedicated_irq(dedicated_irq));
	gpb_pad_model pad_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
	initial begin
		forever #2 aclk = ~aclk;
	end
	task automatic conclude();
		$display("mismatches=%0d comparisons=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(input bit wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] st);
		int i;
		@(posedge aclk);
		if (wr) begin
			{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, st};
			{s_axi_awvalid, s_axi_wvalid} <= 2'b11;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
		end
		// Ready comes late so that answers must be held
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_bvalid && s_axi_bready) begin
				qr = s_axi_bresp;
				break;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				{qr, q} = {s_axi_rresp, s_axi_rdata};
				break;
			end
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (i == 2) {s_axi_bready, s_axi_rready} <= {wr, !wr};
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (i == 40) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		bus(0, a, 0, 0);
		`CHK(q, e)
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rchk({20'h0, `GPB_OFF_DOUT}, 32'h0);
		rchk({20'h1, `GPB_OFF_ALT_CLR}, 32'h1);
		`CHK(pin_oe & ~periph_route, 48'h0)
		rchk({20'h0, `GPB_OFF_DATA}, 32'h5A3C);
		bus(1, {20'h2, `GPB_OFF_PULL_EN}, 32'hFFFF, 4'h3);
		bus(1, {20'h2, `GPB_OFF_PULL_DIR}, 32'h00FF, 4'h3);
		`CHK({pull_up_en[47:32], pull_down_en[47:32]}, 32'h00FF_FF00)
		rchk({20'h2, `GPB_OFF_DATA}, 32'h00FF);
		bus(1, {20'h0, `GPB_OFF_DATA}, 32'h32E8, 4'h3);
		bus(1, {20'h0, `GPB_OFF_OE_SET}, 32'h00FF, 4'h3);
		rchk({20'h0, `GPB_OFF_OE_CLR}, 32'h00FF);
		bus(1, {20'h0, `GPB_OFF_OE_CLR}, 32'h000F, 4'h3);
		rchk({20'h0, `GPB_OFF_OE_SET}, 32'h00F0);
		`CHK({pin_oe[15:0], pin_out[15:0]}, 32'h00F0_32E8)
		bus(1, {20'h0, 12'h70C}, 32'h0003, 4'h3);
		bus(1, {20'h0, 12'hBC0}, 32'hA500, 4'h0);
		rchk({20'h0, `GPB_OFF_DOUT}, 32'hA22B);
		bus(1, {20'h0, `GPB_OFF_DOUT}, 32'hFFFF, 4'h2);
		rchk({20'h0, `GPB_OFF_DATA}, 32'h5A2C);
		rchk({20'h0, 12'h4FC}, 32'h002C);
		rchk({20'h0, 12'hBC0}, 32'h5000);
		bus(1, {20'h1, `GPB_OFF_ALT_CLR}, 32'h0001, 4'h3);
		bus(1, {20'h0, `GPB_OFF_ALT_SET}, 32'h0100, 4'h3);
		`CHK({periph_route[16], pin_oe[8], pin_out[8]}, 3'b010)
		bus(1, {20'h0, `GPB_OFF_ALT_CLR}, 32'h0100, 4'h3);
		`CHK({periph_route[8], pin_oe[8], pin_out[8]}, 3'b001)
		for (m = 0; m < 5; m++) begin
			bus(1, {20'h1, `GPB_OFF_IEN_CLR}, 32'h2, 4'h3);
			bus(1, {20'h1, m[1] ? `GPB_OFF_IPOL_SET : `GPB_OFF_IPOL_CLR}, 32'h2, 4'h3);
			bus(1, {20'h1, m[0] ? `GPB_OFF_ITYP_SET : `GPB_OFF_ITYP_CLR}, 32'h2, 4'h3);
			@(posedge aclk) ext_val[17] <= ~m[1];
			repeat (4) @(posedge aclk);
			if (m < 4) bus(1, {20'h1, `GPB_OFF_IEN_SET}, 32'h2, 4'h3);
			bus(1, {20'h1, `GPB_OFF_STATUS}, 32'h2, 4'h3);
			`CHK(per_pin_irq_lines[17], 1'b0)
			@(posedge aclk) ext_val[17] <= m[1];
			repeat (2) @(posedge aclk);
			#1 `CHK(per_pin_irq_lines[17], 1'b0)
			@(posedge aclk);
			#1 `CHK({per_pin_irq_lines[17], bank_combined_irq[1], dedicated_irq[1]}, {3{m < 4}})
			@(posedge aclk) ext_val[17] <= ~m[1];
			repeat (4) @(posedge aclk);
			#1 `CHK(per_pin_irq_lines[17], m < 4)
			bus(1, {20'h1, `GPB_OFF_STATUS}, 32'h2, 4'h3);
			rchk({20'h1, `GPB_OFF_STATUS}, 32'h0);
		end
		bus(1, {20'h0, `GPB_OFF_SOFT}, 32'h1, 4'h3);
		bus(1, {20'h2, `GPB_OFF_DOUT}, 32'h1234, 4'h3);
		@(posedge aclk) soft_rst_req <= 1'b1;
		@(posedge aclk) soft_rst_req <= 1'b0;
		rchk({20'h0, `GPB_OFF_DOUT}, 32'hFF2B);
		rchk({20'h2, `GPB_OFF_DOUT}, 32'h0);
		`CHK(pull_up_en[47:32], 16'h0)
		bus(0, {20'h3, 12'h000}, 0, 0);
		`CHK({qr, q}, {`GPB_RESP_SLVERR, 32'h0})
		bus(1, {20'h0, 12'h048}, 32'hFFFF, 4'h3);
		`CHK(qr, `GPB_RESP_SLVERR)
		@(posedge aclk) aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rchk({20'h0, `GPB_OFF_DOUT}, 32'h0);
		`CHK(periph_route, ALT)
		conclude();
	end
endmodule
`default_nettype wire
